/* File: hdl/cache_way_reduction_tlb_error.sv */
// Error-driven cache way reduction and TLB error handling.
// Assumes error inputs are one-cycle pulses synchronous to mclk_in.
//
// The Avalon-MM register port and the register addresses were decided locally.
`timescale 1ns/1ps
`include "way_reduction_params.svh"
module cache_way_reduction_tlb_error
  import way_reduction_pkg::*;
(
  input wire logic mclk_in,
  input wire logic reset_n_in,
  input wire logic [5:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  input wire logic l1i_tag_par_err_in,
  input wire logic l1i_dup_tag_par_err_in,
  input wire logic l1i_data_par_err_in,
  input wire logic [`WAY_W-1:0] l1i_err_way_in,
  input wire logic [`IDX_W-1:0] l1i_err_idx_in,
  input wire logic l1d_tag_par_err_in,
  input wire logic l1d_dup_tag_par_err_in,
  input wire logic l1d_data_ce_in,
  input wire logic l1d_data_unmarked_ue_in,
  input wire logic [`WAY_W-1:0] l1d_err_way_in,
  input wire logic [`IDX_W-1:0] l1d_err_idx_in,
  input wire logic l2_tag_ce_in,
  input wire logic l2_tag_ue_in,
  input wire logic l2_data_ce_in,
  input wire logic l2_data_unmarked_ue_in,
  input wire logic [`WAY_W-1:0] l2_err_way_in,
  input wire logic chk_valid_in,
  input wire logic chk_direct_in,
  input wire logic chk_instr_in,
  input wire logic chk_full_in,
  input wire logic [`TAG_W-1:0] set_assoc_tlb_tag_in,
  input wire logic set_assoc_tlb_tag_par_in,
  input wire logic [`DAT_W-1:0] set_assoc_tlb_data_in,
  input wire logic set_assoc_tlb_data_par_in,
  input wire logic [2:0] set_assoc_tlb_lock_in,
  input wire logic [1:0][`TAG_W-1:0] full_assoc_tlb_tag_in,
  input wire logic [1:0] full_assoc_tlb_tag_par_in,
  input wire logic [1:0][`DAT_W-1:0] full_assoc_tlb_data_in,
  input wire logic [1:0] full_assoc_tlb_data_par_in,
  output logic l1i_inv_entry_out,
  output logic l1i_inv_way_out,
  output logic [`WAY_W-1:0] l1i_way_out,
  output logic [`IDX_W-1:0] l1i_idx_out,
  output logic [`WAYS-1:0] l1i_way_disable_out,
  output logic l1d_wb_inv_entry_out,
  output logic l1d_wb_inv_way_out,
  output logic [`WAY_W-1:0] l1d_way_out,
  output logic [`IDX_W-1:0] l1d_idx_out,
  output logic [`WAYS-1:0] l1d_way_disable_out,
  output logic l2_inv_all_out,
  output logic [`WAYS-1:0] l2_way_disable_out,
  output logic restrainable_err_out,
  output logic instr_urgent_err_out,
  output logic fatal_err_out,
  output logic set_assoc_tlb_inv_out,
  output logic set_assoc_tlb_lock_out,
  output logic [1:0] full_assoc_tlb_fix_tag_out,
  output logic [1:0] full_assoc_tlb_fix_data_out
);
  state_t s_r;
  state_t s_nxt;

  // Returns {trip, new count}; trip resets the count so one burst trips once
  function automatic logic [`CNT_W:0] cnt_step(input logic [`CNT_W-1:0] cnt, input logic hit,
                                              input logic [`CNT_W-1:0] thr);
    logic [`CNT_W:0] inc;
    inc = {1'b0, cnt} + {{`CNT_W{1'b0}}, hit};
    if (hit && (inc > {1'b0, thr})) begin
      cnt_step = {1'b1, {`CNT_W{1'b0}}};
    end else if (inc[`CNT_W]) begin
      cnt_step = {1'b0, cnt};
    end else begin
      cnt_step = inc;
    end
  endfunction

  function automatic logic par_bad32(input logic [31:0] d, input logic p);
    par_bad32 = (^d) != p;
  endfunction

  function automatic logic [2:0] count_ones(input logic [`WAYS-1:0] m);
    count_ones = 3'h0;
    for (int i = 0; i < `WAYS; i++) begin
      count_ones = count_ones + {2'h0, m[i]};
    end
  endfunction

  logic l1i_hit;
  logic l1d_hit;
  logic l2_hit;
  logic [`WAYS-1:0] l1i_trip;
  logic [`WAYS-1:0] l1d_trip;
  logic [`WAYS-1:0] l2_trip;
  logic win_end;
  logic st_tag_bad;
  logic st_data_bad;
  logic st_bad;
  logic [1:0] ft_tag_bad;
  logic [1:0] ft_data_bad;
  logic ft_bad;
  logic tlb_bad;
  logic req;

  assign l1i_hit = l1i_tag_par_err_in | l1i_dup_tag_par_err_in | l1i_data_par_err_in;
  assign l1d_hit = l1d_tag_par_err_in | l1d_dup_tag_par_err_in | l1d_data_ce_in | l1d_data_unmarked_ue_in;
  assign l2_hit = l2_tag_ce_in | l2_tag_ue_in | l2_data_ce_in | l2_data_unmarked_ue_in;
  assign win_end = (s_r.win_cnt >= s_r.window);

  assign st_tag_bad = par_bad32(set_assoc_tlb_tag_in, set_assoc_tlb_tag_par_in);
  assign st_data_bad = par_bad32(set_assoc_tlb_data_in, set_assoc_tlb_data_par_in);
  assign st_bad = st_tag_bad | st_data_bad;
  assign ft_tag_bad = {par_bad32(full_assoc_tlb_tag_in[1], full_assoc_tlb_tag_par_in[1]),
                       par_bad32(full_assoc_tlb_tag_in[0], full_assoc_tlb_tag_par_in[0])};
  assign ft_data_bad = {par_bad32(full_assoc_tlb_data_in[1], full_assoc_tlb_data_par_in[1]),
                        par_bad32(full_assoc_tlb_data_in[0], full_assoc_tlb_data_par_in[0])};
  assign ft_bad = |{ft_tag_bad, ft_data_bad};
  assign tlb_bad = chk_full_in ? ft_bad : st_bad;
  assign req = avs_read_in | avs_write_in;

  always_comb begin
    logic [`CNT_W:0] step;
    logic [2:0] set_af;
    logic [1:0] set_ug;
    logic wr;
    step = '0;
    set_af = 3'h0;
    set_ug = 2'h0;
    wr = avs_write_in & s_r.ack;
    s_nxt = s_r;
    l1i_trip = '0;
    l1d_trip = '0;
    l2_trip = '0;
    s_nxt.l1i_inv_entry = 1'b0;
    s_nxt.l1i_inv_way = 1'b0;
    s_nxt.l1d_wb_inv_entry = 1'b0;
    s_nxt.l1d_wb_inv_way = 1'b0;
    s_nxt.l2_inv_all = 1'b0;
    s_nxt.restrain = 1'b0;
    s_nxt.urgent = 1'b0;
    s_nxt.fatal = 1'b0;
    s_nxt.set_assoc_tlb_inv = 1'b0;
    s_nxt.full_assoc_tlb_fix_tag = 2'h0;
    s_nxt.full_assoc_tlb_fix_data = 2'h0;
    s_nxt.win_cnt = win_end ? '0 : s_r.win_cnt + 1'b1;
    for (int w = 0; w < `WAYS; w++) begin
      step = cnt_step(s_r.l1i_cnt[w], l1i_hit && (l1i_err_way_in == w[`WAY_W-1:0]), s_r.thresh);
      s_nxt.l1i_cnt[w] = win_end ? '0 : step[`CNT_W-1:0];
      l1i_trip[w] = step[`CNT_W];
      step = cnt_step(s_r.l1d_cnt[w], l1d_hit && (l1d_err_way_in == w[`WAY_W-1:0]), s_r.thresh);
      s_nxt.l1d_cnt[w] = win_end ? '0 : step[`CNT_W-1:0];
      l1d_trip[w] = step[`CNT_W];
      step = cnt_step(s_r.l2_cnt[w], l2_hit && !s_r.l2_dis[w] && (l2_err_way_in == w[`WAY_W-1:0]),
                      s_r.thresh);
      s_nxt.l2_cnt[w] = win_end ? '0 : step[`CNT_W-1:0];
      l2_trip[w] = step[`CNT_W];
    end
    if (|l1i_trip) begin
      s_nxt.l1_way = l1i_err_way_in;
      s_nxt.l1i_idx = l1i_err_idx_in;
      if (|s_r.l1i_dis) begin
        // Entry only once a way is gone
        s_nxt.l1i_inv_entry = 1'b1;
      end else begin
        // Whole way out, flag and error
        s_nxt.l1i_inv_way = 1'b1;
        s_nxt.l1i_dis[l1i_err_way_in] = 1'b1;
        set_af[`AFSR_L1I_BIT] = 1'b1;
        s_nxt.restrain = 1'b1;
      end
    end
    if (|l1d_trip) begin
      s_nxt.l1d_way = l1d_err_way_in;
      s_nxt.l1d_idx = l1d_err_idx_in;
      if (|s_r.l1d_dis) begin
        s_nxt.l1d_wb_inv_entry = 1'b1;
      end else begin
        // Flush dirty lines, drop the way
        s_nxt.l1d_wb_inv_way = 1'b1;
        s_nxt.l1d_dis[l1d_err_way_in] = 1'b1;
        set_af[`AFSR_L1D_BIT] = 1'b1;
        s_nxt.restrain = 1'b1;
      end
    end
    // Only one pending level two reduction; later trips while pending are dropped
    if ((|l2_trip) && (s_r.l2_st == L2_IDLE)) begin
      s_nxt.l2_st = L2_PENDING;
      s_nxt.l2_way = l2_err_way_in;
    end
    case (s_r.l2_st)
      L2_PENDING: begin
        if (!s_r.hold) begin
          s_nxt.l2_st = L2_IDLE;
          s_nxt.l2_inv_all = 1'b1;
          set_af[`AFSR_L2_BIT] = 1'b1;
          s_nxt.restrain = 1'b1;
          if (count_ones(~s_r.l2_dis) > 3'h1) begin
            s_nxt.l2_dis[s_r.l2_way] = 1'b1;
          end
        end
      end
      default: begin
      end
    endcase
    // Checks on translation and direct reads
    if (chk_valid_in) begin
      if (chk_direct_in) begin
        if (tlb_bad) begin
          set_ug[chk_instr_in ? `UGESR_ITLB_BIT : `UGESR_DTLB_BIT] = 1'b1;
          s_nxt.urgent = 1'b1;
        end
      end else if (!chk_full_in) begin
        s_nxt.set_assoc_tlb_inv = st_bad;
      end else begin
        // Repair bad copy from good one
        s_nxt.full_assoc_tlb_fix_tag = (ft_tag_bad == 2'b01) ? 2'b01 : ((ft_tag_bad == 2'b10) ? 2'b10 : 2'b00);
        s_nxt.full_assoc_tlb_fix_data = (ft_data_bad == 2'b01) ? 2'b01 : ((ft_data_bad == 2'b10) ? 2'b10 : 2'b00);
        s_nxt.fatal = (&ft_tag_bad) | (&ft_data_bad);
      end
    end
    s_nxt.lock = (set_assoc_tlb_lock_in[0] & set_assoc_tlb_lock_in[1]) |
                 (set_assoc_tlb_lock_in[0] & set_assoc_tlb_lock_in[2]) |
                 (set_assoc_tlb_lock_in[1] & set_assoc_tlb_lock_in[2]);
    // Bus: one wait cycle, then answer; status writes are write-one-to-clear
    s_nxt.ack = req & ~s_r.ack;
    if (wr) begin
      if (avs_address_in == `REG_CTRL) begin
        s_nxt.hold = avs_writedata_in[`CTRL_HOLD_BIT];
      end else if (avs_address_in == `REG_THRESH) begin
        s_nxt.thresh = avs_writedata_in[`CNT_W-1:0];
      end else if (avs_address_in == `REG_WINDOW) begin
        s_nxt.window = avs_writedata_in[`WIN_W-1:0];
      end else if (avs_address_in == `REG_AFSR) begin
        s_nxt.afsr = s_r.afsr & ~avs_writedata_in[2:0];
      end else if (avs_address_in == `REG_UGESR) begin
        s_nxt.ugesr = s_r.ugesr & ~avs_writedata_in[1:0];
      end
    end
    // Hardware set wins over a same-cycle software clear
    s_nxt.afsr = s_nxt.afsr | set_af;
    s_nxt.ugesr = s_nxt.ugesr | set_ug;
    if (req && !s_r.ack) begin
      if (avs_address_in == `REG_CTRL) begin
        s_nxt.rdata = {31'h0, s_r.hold};
      end else if (avs_address_in == `REG_THRESH) begin
        s_nxt.rdata = {{(32-`CNT_W){1'b0}}, s_r.thresh};
      end else if (avs_address_in == `REG_WINDOW) begin
        s_nxt.rdata = {{(32-`WIN_W){1'b0}}, s_r.window};
      end else if (avs_address_in == `REG_AFSR) begin
        s_nxt.rdata = {29'h0, s_r.afsr};
      end else if (avs_address_in == `REG_UGESR) begin
        s_nxt.rdata = {30'h0, s_r.ugesr};
      end else if (avs_address_in == `REG_WAYMASK) begin
        s_nxt.rdata = {20'h0, s_r.l2_dis, s_r.l1d_dis, s_r.l1i_dis};
      end else begin
        s_nxt.rdata = 32'h0;
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!reset_n_in) begin
      s_r <= '0;
      s_r.hold <= `HOLD_RST;
      s_r.thresh <= `THRESH_RST;
      s_r.window <= `WINDOW_RST;
      s_r.l2_st <= L2_IDLE;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign avs_readdata_out = s_r.rdata;
  assign avs_waitrequest_out = req & ~s_r.ack;
  assign l1i_inv_entry_out = s_r.l1i_inv_entry;
  assign l1i_inv_way_out = s_r.l1i_inv_way;
  assign l1i_way_out = s_r.l1_way;
  assign l1i_idx_out = s_r.l1i_idx;
  assign l1i_way_disable_out = s_r.l1i_dis;
  assign l1d_wb_inv_entry_out = s_r.l1d_wb_inv_entry;
  assign l1d_wb_inv_way_out = s_r.l1d_wb_inv_way;
  assign l1d_way_out = s_r.l1d_way;
  assign l1d_idx_out = s_r.l1d_idx;
  assign l1d_way_disable_out = s_r.l1d_dis;
  assign l2_inv_all_out = s_r.l2_inv_all;
  assign l2_way_disable_out = s_r.l2_dis;
  assign restrainable_err_out = s_r.restrain;
  assign instr_urgent_err_out = s_r.urgent;
  assign fatal_err_out = s_r.fatal;
  assign set_assoc_tlb_inv_out = s_r.set_assoc_tlb_inv;
  assign set_assoc_tlb_lock_out = s_r.lock;
  assign full_assoc_tlb_fix_tag_out = s_r.full_assoc_tlb_fix_tag;
  assign full_assoc_tlb_fix_data_out = s_r.full_assoc_tlb_fix_data;

  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!reset_n_in);

  l1i_way_drop_a: assert property (s_r.l1i_inv_way |-> restrainable_err_out && s_r.afsr[`AFSR_L1I_BIT])
    else $error("L1I way drop without flag or error");
  // Restrainable error is shared, so only an error with no other source counts here
  l1i_entry_only_a: assert property (s_r.l1i_inv_entry |-> $stable(l1i_way_disable_out) &&
    !(restrainable_err_out && !s_r.l1d_wb_inv_way && !s_r.l2_inv_all))
    else $error("L1I entry invalidate changed ways");
  l1d_way_drop_a: assert property (s_r.l1d_wb_inv_way |-> $countones(l1d_way_disable_out) == 1)
    else $error("L1D first drop not one way");
  l1d_entry_only_a: assert property (s_r.l1d_wb_inv_entry |-> |$past(s_r.l1d_dis))
    else $error("L1D entry flush with no degraded way");
  l2_hold_wait_a: assert property (s_r.hold && s_r.l2_st == L2_PENDING |=> !l2_inv_all_out)
    else $error("L2 reduction under hold");
  l2_last_way_a: assert property (l2_inv_all_out |-> l2_way_disable_out != '1 && restrainable_err_out)
    else $error("L2 lost its last way");
  l2_drop_a: assert property (l2_way_disable_out != $past(l2_way_disable_out) |-> l2_inv_all_out)
    else $error("L2 way disabled without invalidate");
  urgent_flag_a: assert property (chk_valid_in && chk_direct_in && tlb_bad
    |=> instr_urgent_err_out ##0 |s_r.ugesr)
    else $error("Urgent error missing");
  itlb_flag_a: assert property (chk_valid_in && chk_direct_in && chk_instr_in && tlb_bad
    |=> s_r.ugesr[`UGESR_ITLB_BIT])
    else $error("ITLB urgent flag missing");
  tlb_silent_inv_a: assert property (set_assoc_tlb_inv_out |-> !instr_urgent_err_out && !fatal_err_out)
    else $error("Silent TLB invalidate reported");
  tlb_double_bad_a: assert property (chk_valid_in && !chk_direct_in && chk_full_in && (&ft_tag_bad)
    |=> fatal_err_out)
    else $error("Double copy error not fatal");
  tlb_copy_fix_a: assert property (chk_valid_in && !chk_direct_in && chk_full_in && ft_tag_bad == 2'b01
    |=> full_assoc_tlb_fix_tag_out == 2'b01 && !fatal_err_out)
    else $error("Bad tag copy not repaired");
  win_clear_a: assert property (win_end |=> s_r.l1i_cnt == '0 && s_r.l2_cnt == '0)
    else $error("Counters survived window end");
  bus_wait_a: assert property (req && !avs_waitrequest_out |=> !s_r.ack)
    else $error("Bus answer longer than one cycle");

  l1i_drop_c: cover property (s_r.l1i_inv_way ##[1:100] s_r.l1i_inv_entry);
  l2_pend_c: cover property (s_r.l2_st == L2_PENDING && s_r.hold ##[1:300] l2_inv_all_out);
  tlb_copy_fix_c: cover property (|full_assoc_tlb_fix_tag_out);
  urgent_c: cover property (instr_urgent_err_out);
endmodule

/* File: hdl/way_reduction_params.svh */
// Constants for the cache way reduction and TLB error block.
// Included by the package and the design; definitions only.
`ifndef WAY_REDUCTION_PARAMS_SVH
`define WAY_REDUCTION_PARAMS_SVH
`define WAYS 4
`define WAY_W 2
`define IDX_W 8
`define TAG_W 32
`define DAT_W 32
`define CNT_W 8
`define WIN_W 24
// Avalon register offsets (byte addresses)
`define REG_CTRL 6'h00
`define REG_THRESH 6'h04
`define REG_WINDOW 6'h08
`define REG_AFSR 6'h0c
`define REG_UGESR 6'h10
`define REG_WAYMASK 6'h14
// Field positions
`define CTRL_HOLD_BIT 0
`define AFSR_L1I_BIT 0
`define AFSR_L1D_BIT 1
`define AFSR_L2_BIT 2
`define UGESR_DTLB_BIT 0
`define UGESR_ITLB_BIT 1
// Reset values
`define THRESH_RST 8'h04
`define WINDOW_RST 24'h0f4240
`define HOLD_RST 1'b0
`endif

/* File: hdl/way_reduction_pkg.sv */
// Types for the cache way reduction and TLB error block.
// Assumes the params header is on the include path.
`include "way_reduction_params.svh"
package way_reduction_pkg;
  typedef logic [`WAYS-1:0][`CNT_W-1:0] way_cnt_t;
  typedef logic [`WAYS-1:0] way_mask_t;
  typedef enum logic [1:0] {L2_IDLE, L2_PENDING} l2_state_t;
  typedef struct packed {
    logic hold;
    logic [`CNT_W-1:0] thresh;
    logic [`WIN_W-1:0] window;
    logic [`WIN_W-1:0] win_cnt;
    way_cnt_t l1i_cnt;
    way_cnt_t l1d_cnt;
    way_cnt_t l2_cnt;
    way_mask_t l1i_dis;
    way_mask_t l1d_dis;
    way_mask_t l2_dis;
    l2_state_t l2_st;
    logic [`WAY_W-1:0] l2_way;
    logic [2:0] afsr;
    logic [1:0] ugesr;
    logic ack;
    logic [31:0] rdata;
    logic l1i_inv_entry;
    logic l1i_inv_way;
    logic l1d_wb_inv_entry;
    logic l1d_wb_inv_way;
    logic l2_inv_all;
    logic [`WAY_W-1:0] l1_way;
    logic [`WAY_W-1:0] l1d_way;
    logic [`IDX_W-1:0] l1i_idx;
    logic [`IDX_W-1:0] l1d_idx;
    logic restrain;
    logic urgent;
    logic fatal;
    logic set_assoc_tlb_inv;
    logic [1:0] full_assoc_tlb_fix_tag;
    logic [1:0] full_assoc_tlb_fix_data;
    logic lock;
  } state_t;
endpackage

/* File: testbench/cache_ctrl_model.sv */
// Far-side cache and TLB controller model: absorbs action pulses.
// Assumes every action output of the block is a one-cycle pulse on mclk_in.
`timescale 1ns/1ps
module cache_ctrl_model (
  input wire logic mclk_in,
  input wire logic clr_in,
  input wire logic [8:0] ev_in,
  output logic [8:0][7:0] cnt_out
);
  // Counts held until cleared, so a pulse is missed only in a cycle with clr_in high
  always_ff @(posedge mclk_in) begin
    for (int k = 0; k < 9; k++) begin
      if (clr_in) begin
        cnt_out[k] <= 8'h00;
      end else if (ev_in[k]) begin
        cnt_out[k] <= cnt_out[k] + 8'h01;
      end
    end
  end
endmodule

/* File: testbench/cache_way_reduction_tlb_error_tb.sv */
// Self-checking bench for the way reduction and TLB error block.
// Assumes the params header on the include path and one 50 MHz clock.
`timescale 1ns/1ps
`include "way_reduction_params.svh"
module cache_way_reduction_tlb_error_tb;
  logic mclk_in, reset_n_in, avs_read_in, avs_write_in, avs_waitrequest_out, clr;
  logic [5:0] avs_address_in;
  logic [31:0] avs_writedata_in, avs_readdata_out, set_assoc_tlb_tag_in, set_assoc_tlb_data_in, rd;
  logic [2:0] l1i_e, set_assoc_tlb_lock_in;
  logic [3:0] l1d_e, l2_e, l1i_way_disable_out, l1d_way_disable_out, l2_way_disable_out;
  logic [1:0] ew, l1i_way_out, l1d_way_out, full_assoc_tlb_tag_par_in, full_assoc_tlb_data_par_in;
  logic [1:0] full_assoc_tlb_fix_tag_out, full_assoc_tlb_fix_data_out;
  logic [7:0] ei, l1i_idx_out, l1d_idx_out, r;
  logic chk_valid_in, chk_direct_in, chk_instr_in, chk_full_in, set_assoc_tlb_lock_out;
  logic set_assoc_tlb_tag_par_in, set_assoc_tlb_data_par_in;
  logic [1:0][31:0] full_assoc_tlb_tag_in, full_assoc_tlb_data_in;
  logic l1i_inv_entry_out, l1i_inv_way_out, l1d_wb_inv_entry_out, l1d_wb_inv_way_out, l2_inv_all_out;
  logic restrainable_err_out, instr_urgent_err_out, fatal_err_out, set_assoc_tlb_inv_out;
  logic [8:0][7:0] cnt;
  int errors, samples_checked, cycles;

  cache_way_reduction_tlb_error DUT (.mclk_in, .reset_n_in, .avs_address_in, .avs_read_in, .avs_write_in,
    .avs_writedata_in, .avs_readdata_out, .avs_waitrequest_out, .l1i_tag_par_err_in(l1i_e[0]),
    .l1i_dup_tag_par_err_in(l1i_e[1]), .l1i_data_par_err_in(l1i_e[2]), .l1i_err_way_in(ew), .l1i_err_idx_in(ei),
    .l1d_tag_par_err_in(l1d_e[0]), .l1d_dup_tag_par_err_in(l1d_e[1]), .l1d_data_ce_in(l1d_e[2]),
    .l1d_data_unmarked_ue_in(l1d_e[3]), .l1d_err_way_in(ew), .l1d_err_idx_in(ei), .l2_tag_ce_in(l2_e[0]),
    .l2_tag_ue_in(l2_e[1]), .l2_data_ce_in(l2_e[2]), .l2_data_unmarked_ue_in(l2_e[3]), .l2_err_way_in(ew),
    .chk_valid_in, .chk_direct_in, .chk_instr_in, .chk_full_in, .set_assoc_tlb_tag_in, .set_assoc_tlb_tag_par_in,
    .set_assoc_tlb_data_in, .set_assoc_tlb_data_par_in, .set_assoc_tlb_lock_in, .full_assoc_tlb_tag_in,
    .full_assoc_tlb_tag_par_in, .full_assoc_tlb_data_in, .full_assoc_tlb_data_par_in,
    .l1i_inv_entry_out, .l1i_inv_way_out, .l1i_way_out, .l1i_idx_out, .l1i_way_disable_out, .l1d_wb_inv_entry_out,
    .l1d_wb_inv_way_out, .l1d_way_out, .l1d_idx_out, .l1d_way_disable_out, .l2_inv_all_out, .l2_way_disable_out,
    .restrainable_err_out, .instr_urgent_err_out, .fatal_err_out, .set_assoc_tlb_inv_out, .set_assoc_tlb_lock_out,
    .full_assoc_tlb_fix_tag_out, .full_assoc_tlb_fix_data_out);

  cache_ctrl_model partner (.mclk_in, .clr_in(clr), .cnt_out(cnt), .ev_in({set_assoc_tlb_inv_out, fatal_err_out,
    instr_urgent_err_out, restrainable_err_out, l2_inv_all_out, l1d_wb_inv_way_out, l1d_wb_inv_entry_out,
    l1i_inv_way_out, l1i_inv_entry_out}));

  initial begin
    mclk_in = 1'b0;
    forever #10 mclk_in = ~mclk_in;
  end

  always @(posedge mclk_in) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors++;
      complete_run();
    end
  end

  task complete_run;
    $display("errors=%0d samples_checked=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Each event in nz seen exactly once, all others never
  task chk_ev(input logic [8:0] nz);
    logic [8:0][7:0] e;
    repeat (6) @(posedge mclk_in);
    @(negedge mclk_in);
    for (int k = 0; k < 9; k++) begin
      e[k] = {7'h0, nz[k]};
    end
    samples_checked++;
    if (cnt !== e) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, cnt, e);
    end
    @(posedge mclk_in);
    clr <= 1'b1;
    @(posedge mclk_in);
    clr <= 1'b0;
  endtask

  // Request held until waitrequest is seen low at a rising edge
  task bus(input logic wr, input logic [5:0] a, input logic [31:0] wd);
    @(posedge mclk_in);
    avs_address_in <= a;
    avs_writedata_in <= wd;
    avs_write_in <= wr;
    avs_read_in <= !wr;
    @(posedge mclk_in);
    while (avs_waitrequest_out !== 1'b0) @(posedge mclk_in);
    rd = avs_readdata_out;
    avs_read_in <= 1'b0;
    avs_write_in <= 1'b0;
  endtask

  task rdchk(input logic [5:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  task inj(input int c, input int k, input logic [1:0] w);
    @(posedge mclk_in);
    ew <= w;
    ei <= {6'h15, w};
    case (c)
      0: l1i_e[k] <= 1'b1;
      1: l1d_e[k] <= 1'b1;
      default: l2_e[k] <= 1'b1;
    endcase
    @(posedge mclk_in);
    {l1i_e, l1d_e, l2_e} <= '0;
  endtask

  // Kinds rotate so every counted error source is used
  task burst(input int c, input logic [1:0] w, input int n, input int off);
    for (int i = 0; i < n; i++) begin
      inj(c, (off + i) % (c == 0 ? 3 : 4), w);
    end
  endtask

  // Bad bits: [1:0] tag copies, [3:2] data copies; copy 0 is the set-assoc entry
  task tlb(input logic d, input logic i, input logic f, input logic [3:0] bad, input logic [2:0] lk);
    @(posedge mclk_in);
    {chk_valid_in, chk_direct_in, chk_instr_in, chk_full_in} <= {1'b1, d, i, f};
    set_assoc_tlb_tag_in <= 32'h3;
    set_assoc_tlb_tag_par_in <= bad[0];
    set_assoc_tlb_data_in <= 32'h1;
    set_assoc_tlb_data_par_in <= !bad[2];
    full_assoc_tlb_tag_in <= {2{32'h3}};
    full_assoc_tlb_tag_par_in <= bad[1:0];
    full_assoc_tlb_data_in <= {2{32'h1}};
    full_assoc_tlb_data_par_in <= ~bad[3:2];
    set_assoc_tlb_lock_in <= lk;
    @(posedge mclk_in);
    chk_valid_in <= 1'b0;
    @(negedge mclk_in);
    r = {fatal_err_out, instr_urgent_err_out, set_assoc_tlb_inv_out, set_assoc_tlb_lock_out,
         full_assoc_tlb_fix_tag_out, full_assoc_tlb_fix_data_out};
  endtask

  task t_regs;
    rdchk(`REG_THRESH, 32'h4);
    rdchk(`REG_WINDOW, 32'h0f4240);
    rdchk(`REG_CTRL, 32'h0);
    rdchk(6'h18, 32'h0);
    bus(1'b1, `REG_WAYMASK, 32'hffffffff);
    rdchk(`REG_WAYMASK, 32'h0);
    bus(1'b1, `REG_THRESH, 32'h3);
    rdchk(`REG_THRESH, 32'h3);
  endtask

  task t_l1;
    burst(0, 2'h2, 3, 0);
    chk_ev(9'h000);
    burst(0, 2'h2, 1, 3);
    chk_ev(9'h022);
    chk(l1i_way_out, 32'h2);
    rdchk(`REG_WAYMASK, 32'h4);
    chk(l1i_way_disable_out, 32'h4);
    rdchk(`REG_AFSR, 32'h1);
    bus(1'b1, `REG_AFSR, 32'h1);
    rdchk(`REG_AFSR, 32'h0);
    burst(0, 2'h1, 4, 0);
    chk_ev(9'h001);
    chk(l1i_idx_out, 32'h55);
    rdchk(`REG_WAYMASK, 32'h4);
    burst(1, 2'h1, 4, 0);
    chk_ev(9'h028);
    chk(l1d_way_out, 32'h1);
    rdchk(`REG_WAYMASK, 32'h24);
    chk(l1d_way_disable_out, 32'h2);
    burst(1, 2'h3, 4, 0);
    chk_ev(9'h004);
    chk(l1d_idx_out, 32'h57);
    rdchk(`REG_AFSR, 32'h2);
  endtask

  task t_l2;
    bus(1'b1, `REG_CTRL, 32'h1);
    burst(2, 2'h0, 4, 0);
    repeat (20) @(posedge mclk_in);
    chk_ev(9'h000);
    bus(1'b1, `REG_CTRL, 32'h0);
    chk_ev(9'h030);
    rdchk(`REG_WAYMASK, 32'h124);
    rdchk(`REG_AFSR, 32'h6);
    burst(2, 2'h1, 4, 0);
    chk_ev(9'h030);
    burst(2, 2'h2, 4, 0);
    chk_ev(9'h030);
    chk(l2_way_disable_out, 32'h7);
    // Last usable way is flushed but stays enabled
    burst(2, 2'h3, 4, 0);
    chk_ev(9'h030);
    rdchk(`REG_WAYMASK, 32'h724);
  endtask

  task t_win;
    bus(1'b1, `REG_WINDOW, 32'd20);
    for (int i = 0; i < 4; i++) begin
      inj(0, 0, 2'h0);
      repeat (10) @(posedge mclk_in);
    end
    chk_ev(9'h000);
  endtask

  task t_tlb;
    tlb(1'b1, 1'b0, 1'b0, 4'h1, 3'h0);
    chk(r, 32'h40);
    chk_ev(9'h040);
    rdchk(`REG_UGESR, 32'h1);
    tlb(1'b1, 1'b1, 1'b1, 4'h8, 3'h0);
    chk(r, 32'h40);
    chk_ev(9'h040);
    tlb(1'b0, 1'b0, 1'b0, 4'h4, 3'h6);
    chk(r, 32'h30);
    chk_ev(9'h100);
    tlb(1'b0, 1'b1, 1'b1, 4'h1, 3'h1);
    chk(r, 32'h04);
    tlb(1'b0, 1'b0, 1'b1, 4'h8, 3'h0);
    chk(r, 32'h02);
    tlb(1'b0, 1'b0, 1'b1, 4'hc, 3'h5);
    chk(r, 32'h90);
    chk_ev(9'h080);
    tlb(1'b0, 1'b0, 1'b0, 4'h0, 3'h3);
    chk(r, 32'h10);
    rdchk(`REG_UGESR, 32'h3);
    bus(1'b1, `REG_UGESR, 32'h3);
    rdchk(`REG_UGESR, 32'h0);
  endtask

  initial begin
    {avs_read_in, avs_write_in, avs_address_in, avs_writedata_in, l1i_e, l1d_e, l2_e, ew, ei} = '0;
    {chk_valid_in, chk_direct_in, chk_instr_in, chk_full_in, set_assoc_tlb_tag_in, set_assoc_tlb_data_in} = '0;
    {set_assoc_tlb_tag_par_in, set_assoc_tlb_data_par_in, set_assoc_tlb_lock_in} = '0;
    {full_assoc_tlb_tag_in, full_assoc_tlb_data_in} = '0;
    {full_assoc_tlb_tag_par_in, full_assoc_tlb_data_par_in} = '0;
    {errors, samples_checked, cycles} = '0;
    reset_n_in = 1'b0;
    clr = 1'b1;
    repeat (12) @(posedge mclk_in);
    reset_n_in <= 1'b1;
    clr <= 1'b0;
    t_regs();
    t_l1();
    t_l2();
    t_tlb();
    t_win();
    complete_run();
  end
endmodule
